// >>> core/sac_ctrl.sv
// Serial interface and successive-approximation sequencer of the converter
`timescale 1ns/10ps
// Notes on behaviour
// R1: Serial input sampled on serial clock rise
// R2: Serial input ignored unless chip select low
// R3: Output and strobe released while deselected
// R4: Result bit updated on serial clock rise
// R5: Strobe high one period before MSB
// R6: Shutdown low halts all conversion activity
// R7: Serial clock paces the conversion steps
// R8: Conversion interval lasts fifteen serial periods
// R9: Host keeps serial clock duty 40-60%
// R10: Single-ended: channel positive, ground reference negative
// R11: Differential uses adjacent pairs only
// R12: Acquire three periods, hold after last bit
// R13: Conversion begins by switching to return node
// R14: Each conversion yields a ten-bit result
// R15: Leading zeros skipped, first one starts byte
// R16: Track after fifth bit, hold after eighth
// R17: Host gives twenty-four clocks per conversion
// R18: Result leaves MSB first after strobe
module sac_ctrl
	import sac_pkg::*;
#(
	parameter int RES_W = RES_BITS,
	parameter int CONV_LEN = CONV_PERIODS
)
(
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic din_i,
	input wire logic shutdown_n_i,
	input wire logic comp_i,
	output logic dout_o,
	output logic dout_oe_o,
	output logic conversion_strobe_o,
	output logic conversion_strobe_oe_o,
	output logic track_o,
	output logic hold_to_neg_o,
	output logic [NUM_CH-1:0] pos_sel_o,
	output logic [NUM_CH-1:0] neg_sel_o,
	output logic neg_ref_o,
	output logic [RES_W-1:0] dac_code_o,
	output logic unipolar_o,
	output logic [1:0] pd_mode_o,
	output logic [RES_W-1:0] result_o,
	output logic result_valid_o
);

	// ==========================================================
	// Parameter checks
	// ==========================================================
	localparam int CW = $clog2(CONV_LEN + 1); // Conversion counter width
	// Strobe period plus one period per decision must fit the interval
	if (RES_W < 2 || RES_W + 1 > CONV_LEN)
	begin : g_bad_len
		$error("sac_ctrl: result width does not fit the conversion interval");
	end

	// ==========================================================
	// Declarations
	// ==========================================================
	sac_state_e state; // Sequencer state
	sac_state_e next_state; // Next sequencer state
	logic sclk_q; // Serial clock one cycle ago
	logic [3:0] bit_cnt; // Control bits received, start bit included
	logic [7:0] shreg; // Control byte shift register
	logic [2:0] sel; // Channel select, frozen once complete
	logic [7:0] cfg; // Whole control byte, frozen at hold
	logic [CW-1:0] conv_cnt; // Serial rises seen in the conversion
	logic [RES_W-1:0] trial; // One-hot bit under trial
	logic [RES_W-1:0] code; // Approximation register

	// ==========================================================
	// Edge and condition decode
	// ==========================================================
	// No private oscillator: every step waits for a serial clock edge
	wire sclk_rise = sclk_i & ~sclk_q; // R7
	wire sclk_fall = ~sclk_i & sclk_q; // R7
	// Deselect or shutdown stops everything, din included
	wire abort = cs_n_i | ~shutdown_n_i; // R2 R6
	wire in_idle = (state == ST_IDLE);
	wire in_ctrl = (state == ST_CTRL);
	wire in_conv = (state == ST_CONV);
	// Leading zeros do nothing; the first one is the start bit
	wire start_seen = in_idle & sclk_rise & din_i; // R15 R1
	wire ctrl_shift = in_ctrl & sclk_rise; // R1
	wire byte_done = in_ctrl & sclk_fall & (bit_cnt == CTRL_BITS); // R12 R16
	wire track_go = in_ctrl & sclk_fall & (bit_cnt == TRACK_BIT); // R16
	wire conv_rise = in_conv & sclk_rise;
	wire strobe_go = conv_rise & (conv_cnt == '0); // R5
	wire decide = conv_rise && conv_cnt != '0 && conv_cnt <= CW'(RES_W); // R7
	wire conv_end = conv_rise & (conv_cnt == CW'(CONV_LEN - 1)); // R8
	// Keep the bit under trial only when the sample is above the DAC level
	wire [RES_W-1:0] next_code = (comp_i ? code : (code & ~trial)) | (trial >> 1);
	wire [RES_W-1:0] msb_one = {1'b1, {(RES_W-1){1'b0}}};

	// ==========================================================
	// Next state
	// ==========================================================
	always_comb
	begin
		next_state = state;
		unique case (state)
			ST_IDLE:
			begin
				if (start_seen)
					next_state = ST_CTRL; // R15
			end
			ST_CTRL:
			begin
				if (byte_done)
					next_state = ST_CONV; // R13
			end
			ST_CONV:
			begin
				if (conv_end)
					next_state = ST_IDLE;
			end
		endcase
		if (abort)
			next_state = ST_IDLE; // R6
	end

	// ==========================================================
	// State, edge history and counters
	// ==========================================================
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			state <= ST_IDLE;
			sclk_q <= 1'b0;
			bit_cnt <= 4'h0;
			conv_cnt <= '0;
		end
		else
		begin
			state <= next_state;
			sclk_q <= sclk_i;
			// Count control bits; cleared on abort, set to one by a fresh start
			if (abort || start_seen)
				bit_cnt <= {3'b000, start_seen & ~abort};
			else if (ctrl_shift)
				bit_cnt <= bit_cnt + 4'h1;
			// Conversion periods count from the hold edge
			if (abort || byte_done || conv_end)
				conv_cnt <= '0;
			else if (conv_rise)
				conv_cnt <= conv_cnt + CW'(1); // R8
		end
	end

	// ==========================================================
	// Control byte capture
	// ==========================================================
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			shreg <= 8'h00;
			sel <= 3'b000;
			cfg <= 8'h00;
		end
		else
		begin
			if (start_seen && !abort)
				shreg <= {7'h00, 1'b1};
			else if (ctrl_shift && !abort)
				shreg <= {shreg[6:0], din_i}; // R1 R2
			// Select is known early so the right channel tracks
			if (ctrl_shift && !abort && bit_cnt == SEL_BITS_IN)
				sel <= {shreg[1:0], din_i};
			if (byte_done && !abort)
				cfg <= shreg;
		end
	end

	// ==========================================================
	// Track and hold switches
	// ==========================================================
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			track_o <= 1'b0;
		else if (abort || byte_done)
			track_o <= 1'b0; // R12
		else if (track_go)
			track_o <= 1'b1; // R16
	end

	// Hold capacitor sits on the return node for the whole interval
	assign hold_to_neg_o = in_conv; // R13

	// ==========================================================
	// Approximation and serial output
	// ==========================================================
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			trial <= '0;
			code <= '0;
			dout_o <= 1'b0;
			conversion_strobe_o <= 1'b0;
		end
		else if (abort)
		begin
			// A deselect mid-conversion drops the partial result
			trial <= '0;
			code <= '0;
			dout_o <= 1'b0;
			conversion_strobe_o <= 1'b0;
		end
		else if (strobe_go)
		begin
			trial <= msb_one;
			code <= msb_one;
			conversion_strobe_o <= 1'b1; // R5
		end
		else if (decide)
		begin
			trial <= trial >> 1;
			code <= next_code;
			dout_o <= comp_i; // R4 R18
			conversion_strobe_o <= 1'b0; // R5
		end
		else if (conv_rise)
		begin
			dout_o <= 1'b0; // Trailing periods read as zero
		end
	end

	// ==========================================================
	// Result capture
	// ==========================================================
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			result_o <= '0;
			result_valid_o <= 1'b0;
		end
		else
		begin
			result_valid_o <= conv_end & ~abort;
			if (conv_end && !abort)
				result_o <= code; // R14
		end
	end

	// ==========================================================
	// Pins and analog controls
	// ==========================================================
	assign dout_oe_o = ~cs_n_i; // R3
	assign conversion_strobe_oe_o = ~cs_n_i; // R3
	assign dac_code_o = code;
	assign unipolar_o = cfg[UNI_BIT];
	assign pd_mode_o = cfg[PD_LSB +: 2];

	// Mode bit comes late, only needed once the return node is used
	sac_steer #(
		.NCH(NUM_CH)
	) u_steer (
		.sel_i(sel),
		.single_i(cfg[SGL_BIT]),
		.pos_sel_o(pos_sel_o),
		.neg_sel_o(neg_sel_o),
		.neg_ref_o(neg_ref_o)
	);

	// ==========================================================
	// Assertions
	// ==========================================================
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	a_release_when_deselected: assert property ( // R3
		cs_n_i |-> (!dout_oe_o && !conversion_strobe_oe_o) ##1 in_idle)
		else $error("outputs driven or sequencer busy while deselected");

	a_din_ignored_deselected: assert property ( // R2
		cs_n_i && sclk_rise && din_i |=> in_idle && bit_cnt == 4'h0)
		else $error("serial input taken while deselected");

	a_leading_zero_skip: assert property ( // R15
		in_idle && sclk_rise && !din_i |=> in_idle)
		else $error("leading zero started a control byte");

	a_track_after_fifth: assert property ( // R16
		$rose(track_o) |-> $past(sclk_fall) && $past(bit_cnt) == TRACK_BIT)
		else $error("tracking began at the wrong edge");

	a_hold_after_eighth: assert property ( // R12
		$rose(hold_to_neg_o) |-> !track_o && $past(sclk_fall)
			&& $past(bit_cnt) == CTRL_BITS)
		else $error("hold began at the wrong edge");

	a_strobe_before_msb: assert property ( // R5
		$rose(conversion_strobe_o) |-> hold_to_neg_o && conv_cnt == CW'(1)
			&& !dout_o && trial == msb_one)
		else $error("strobe raised outside the period before the first decision");

	a_strobe_one_period: assert property ( // R5
		$fell(conversion_strobe_o) && !$past(abort) |-> $past(sclk_rise)
			&& conv_cnt == CW'(2))
		else $error("strobe did not last exactly one serial period");

	a_dout_on_rise: assert property ( // R4
		$changed(dout_o) && !$past(abort) |-> $past(sclk_rise) && in_conv)
		else $error("serial output moved off a serial clock rise");

	a_conv_length: assert property ( // R8
		in_conv |-> conv_cnt < CW'(CONV_LEN))
		else $error("conversion interval overran");

	a_shutdown_halts: assert property ( // R6
		!shutdown_n_i |=> !hold_to_neg_o && !track_o && !conversion_strobe_o)
		else $error("conversion continued during shutdown");

	a_single_return: assert property ( // R10
		hold_to_neg_o && cfg[SGL_BIT] |-> neg_ref_o && neg_sel_o == '0
			&& $onehot(pos_sel_o))
		else $error("single-ended return node not on ground reference");

	a_diff_pairs: assert property ( // R11
		hold_to_neg_o && !cfg[SGL_BIT] |-> !neg_ref_o && $onehot(neg_sel_o)
			&& neg_sel_o == (((pos_sel_o & EVEN_CH_MASK) << 1)
			| ((pos_sel_o & ODD_CH_MASK) >> 1)))
		else $error("differential nodes not an adjacent pair");

	a_result_width: assert property ( // R14
		result_valid_o |-> $past(in_conv) && $past(trial) == '0)
		else $error("result posted before all bits were decided");

endmodule : sac_ctrl

// >>> core/sac_pkg.sv
// Shared constants and types of the serial converter control block
package sac_pkg;

	// ==========================================================
	// Control byte layout, first bit received is bit 7 (start)
	// ==========================================================
	localparam logic [3:0] CTRL_BITS = 4'h8; // Bits in the control byte
	localparam logic [3:0] TRACK_BIT = 4'h5; // Tracking starts after this bit
	localparam logic [3:0] SEL_BITS_IN = 4'h3; // Bits held just before the last select bit
	localparam int SEL_LSB = 4; // Channel select field, three bits
	localparam int UNI_BIT = 3; // Unipolar when set
	localparam int SGL_BIT = 2; // Single-ended when set
	localparam int PD_LSB = 0; // Power mode field, two bits

	// ==========================================================
	// Conversion timing in serial clock periods, result width and channel count
	// ==========================================================
	localparam int CONV_PERIODS = 15; // Length of the conversion interval
	localparam int RES_BITS = 10; // Result width
	localparam int NUM_CH = 8; // Analog input channels

	// Even and odd channel masks, used to check pairing
	localparam logic [7:0] EVEN_CH_MASK = 8'h55;
	localparam logic [7:0] ODD_CH_MASK = 8'hAA;

	// ==========================================================
	// Sequencer states, one-hot
	// ==========================================================
	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b001, // Waiting for the start bit
		ST_CTRL = 3'b010, // Shifting in the control byte
		ST_CONV = 3'b100 // Hold capacitor on the return node, deciding bits
	} sac_state_e;

endpackage : sac_pkg

// >>> core/sac_steer.sv
// Input multiplexer steering for the sample and return nodes
`timescale 1ns/10ps
module sac_steer
	import sac_pkg::*;
#(
	parameter int NCH = NUM_CH
)
(
	input wire logic [2:0] sel_i,
	input wire logic single_i,
	output logic [NCH-1:0] pos_sel_o,
	output logic [NCH-1:0] neg_sel_o,
	output logic neg_ref_o
);

	// ==========================================================
	// Decode
	// ==========================================================
	// Select code rotates: low two bits pick the pair, the top bit the odd member
	wire [2:0] pos_ch = {sel_i[1:0], sel_i[2]};
	// The partner of the pair sits on the return node in differential mode
	wire [2:0] neg_ch = {sel_i[1:0], ~sel_i[2]};

	// Elaboration check: the rotated decode only works for one bank of eight
	if (NCH != NUM_CH)
	begin : g_bad_nch
		$error("sac_steer: channel decode serves exactly eight inputs");
	end

	// One switch pair per channel
	genvar i;
	generate
		for (i = 0; i < NCH; i++)
		begin : g_ch
			assign pos_sel_o[i] = (pos_ch == 3'(i)); // R10
			assign neg_sel_o[i] = ~single_i & (neg_ch == 3'(i)); // R11
		end
	endgenerate

	// Single-ended return node is the ground reference input
	assign neg_ref_o = single_i; // R10

endmodule : sac_steer

// >>> verification/sac_host.sv
// Host serial master model that drives the converter's serial link
`timescale 1ns/10ps
module sac_host
(
	input wire logic clk_i,
	output logic sclk_o,
	output logic cs_n_o,
	output logic din_o
);
	// ==========================================================
	// Idle line levels
	// ==========================================================
	initial
	begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		din_o = 1'b0;
	end

	// A released data line keeps changing, so a stale bit never looks valid
	always @(negedge clk_i)
		if (cs_n_o)
			din_o <= ~din_o;

	// ==========================================================
	// Serial periods: three clocks low, three high, so 50% duty
	// ==========================================================
	task pulse(input logic d);
		din_o = d;
		repeat (3) @(negedge clk_i);
		sclk_o = 1'b1;
		repeat (3) @(negedge clk_i);
		sclk_o = 1'b0;
	endtask : pulse

	// Clock pulses while deselected, data line left wandering
	task idle_clocks(input int n);
		repeat (n)
		begin
			repeat (3) @(negedge clk_i);
			sclk_o = 1'b1;
			repeat (3) @(negedge clk_i);
			sclk_o = 1'b0;
		end
	endtask : idle_clocks

	// One framed transfer: leading zeros, control byte, then zeros
	task frame(input logic [7:0] ctrl, input int lead, input int nrise);
		int i;
		repeat (20) @(negedge clk_i);
		cs_n_o = 1'b0;
		@(negedge clk_i);
		for (i = 0; i < nrise; i++)
			pulse((i >= lead && i < lead + 8) ? ctrl[7 - (i - lead)] : 1'b0);
		repeat (3) @(negedge clk_i);
		cs_n_o = 1'b1;
	endtask : frame
endmodule : sac_host

// >>> verification/testbench.sv
// Self-checking bench of the serial converter control block
`timescale 1ns/10ps
module testbench
	import sac_pkg::*;
;
	// ==========================================================
	// Signals and bookkeeping
	// ==========================================================
	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic shutdown_n_i = 1'b1;
	logic comp_i = 1'b0;
	logic sclk_i, cs_n_i, din_i;
	logic dout_o, dout_oe_o, conversion_strobe_o, conversion_strobe_oe_o;
	logic track_o, hold_to_neg_o, neg_ref_o, unipolar_o, result_valid_o;
	logic [7:0] pos_sel_o, neg_sel_o, cap_pos, cap_neg;
	logic [9:0] dac_code_o, result_o, last_res;
	logic [1:0] pd_mode_o;
	logic cap_ref;
	logic [31:0] rng = 32'h000135BF;
	logic dv [0:47];
	logic sv [0:47];
	logic tv [0:47];
	logic hv [0:47];
	int err_total = 0;
	int checks_done = 0;
	int vin = 0;
	int nres = 0;
	int rise_n = 0;
	int trc = 0;
	int stc = 0;
	int cap_at = 0;

	initial
		forever #2.5 clk_i = ~clk_i;

	sac_host host (.clk_i(clk_i), .sclk_o(sclk_i), .cs_n_o(cs_n_i), .din_o(din_i));

	sac_ctrl uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i),
		.din_i(din_i), .shutdown_n_i(shutdown_n_i), .comp_i(comp_i), .dout_o(dout_o),
		.dout_oe_o(dout_oe_o), .conversion_strobe_o(conversion_strobe_o),
		.conversion_strobe_oe_o(conversion_strobe_oe_o), .track_o(track_o),
		.hold_to_neg_o(hold_to_neg_o), .pos_sel_o(pos_sel_o), .neg_sel_o(neg_sel_o),
		.neg_ref_o(neg_ref_o), .dac_code_o(dac_code_o), .unipolar_o(unipolar_o),
		.pd_mode_o(pd_mode_o), .result_o(result_o), .result_valid_o(result_valid_o));

	// Ideal comparator: the held sample is the integer vin
	always @(negedge clk_i)
		comp_i <= (vin >= int'(dac_code_o));

	// ==========================================================
	// Helpers
	// ==========================================================
	task chk(input logic ok, input string msg);
		checks_done++;
		if (ok !== 1'b1)
		begin
			err_total++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask : chk

	function logic [31:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction : xs

	// Behavioural successive approximation, MSB trial first
	function logic [9:0] ref_sar(input int v);
		int r;
		r = 0;
		for (int b = 9; b >= 0; b--)
			if (v >= (r | (1 << b)))
				r = r | (1 << b);
		return r[9:0];
	endfunction : ref_sar

	task final_report();
		$display("mismatches %0d checks %0d", err_total, checks_done);
		if (err_total == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : final_report

	// ==========================================================
	// Monitors
	// ==========================================================
	// Per-cycle counts; the enable check runs every cycle
	always @(posedge clk_i)
	begin
		if (track_o === 1'b1)
			trc++;
		if (conversion_strobe_o === 1'b1)
			stc++;
		if (result_valid_o === 1'b1)
		begin
			nres++;
			last_res = result_o;
		end
		chk(dout_oe_o === ~cs_n_i && conversion_strobe_oe_o === ~cs_n_i, "enable");
	end

	// What the host sees at each rise of its own clock
	always @(posedge sclk_i)
		if (cs_n_i === 1'b0 && rise_n < 48)
		begin
			dv[rise_n] = dout_o;
			sv[rise_n] = conversion_strobe_o;
			tv[rise_n] = track_o;
			hv[rise_n] = hold_to_neg_o;
			if (rise_n == cap_at)
			begin
				cap_pos = pos_sel_o;
				cap_neg = neg_sel_o;
				cap_ref = neg_ref_o;
			end
			rise_n++;
		end

	// One full conversion, compared with the model at every result
	task run(input logic [7:0] ctrl, input int lead);
		logic [9:0] e;
		int k;
		int n0;
		int p;
		e = ref_sar(vin);
		n0 = nres;
		rise_n = 0;
		trc = 0;
		stc = 0;
		cap_at = lead + 10;
		p = {ctrl[5], ctrl[4], ctrl[6]};
		host.frame(ctrl, lead, lead + 24);
		for (k = 0; k < lead + 24; k++)
			chk(sv[k] === (k == lead + 9), "strobe timing");
		for (k = 0; k < 10; k++)
			chk(dv[lead + 10 + k] === e[9 - k], "result bit");
		chk(tv[lead + 4] === 1'b0 && tv[lead + 5] === 1'b1 && tv[lead + 8] === 1'b0, "track");
		chk(trc == 18, "acquire length");
		chk(stc == 6, "strobe width");
		chk(hv[lead + 7] === 1'b0 && hv[lead + 8] === 1'b1 && hv[lead + 22] === 1'b1, "hold");
		chk(cap_pos === 8'h01 << p, "positive node");
		chk(cap_neg === (ctrl[2] ? 8'h00 : 8'h01 << (p ^ 1)) && cap_ref === ctrl[2], "return");
		chk(nres == n0 + 1 && last_res === e, "result word");
		chk(unipolar_o === ctrl[3] && pd_mode_o === ctrl[1:0], "mode bits");
	endtask : run

	// ==========================================================
	// Main sequence
	// ==========================================================
	initial
	begin
		int i;
		int n;
		logic [31:0] r;
		repeat (4) @(negedge clk_i);
		rst_b_i = 1'b1;
		// Clocks while deselected must not start a byte
		host.idle_clocks(3);
		// Every select in both modes, random leading zeros and samples
		for (i = 0; i < 16; i++)
		begin
			r = xs();
			vin = (i == 0) ? 0 : (i == 15) ? 1023 : int'(r[25:16]);
			run({1'b1, i[2:0], r[3], i[3], r[1:0]}, int'(r[5:4]));
		end
		// Deselect in mid-conversion loses the result
		n = nres;
		host.frame(8'hFF, 0, 14);
		// Let one clock edge see the raised chip select before looking
		@(negedge clk_i);
		chk(hold_to_neg_o === 1'b0 && track_o === 1'b0 && nres == n, "deselect abort");
		// Shutdown in mid-conversion stops all activity
		n = nres;
		fork
			host.frame(8'hFF, 1, 25);
			begin
				repeat (90) @(negedge clk_i);
				shutdown_n_i = 1'b0;
			end
		join
		chk(hold_to_neg_o === 1'b0 && conversion_strobe_o === 1'b0 && nres == n, "shutdown");
		@(negedge clk_i);
		shutdown_n_i = 1'b1;
		vin = 341;
		run(8'hF5, 0);
		final_report();
	end

	// Watchdog, well beyond the expected run of some 3300 cycles
	initial
	begin
		repeat (20000) @(posedge clk_i);
		err_total++;
		$display("[FAIL] %0t watchdog expired", $time);
		final_report();
	end
endmodule : testbench
